// file: logic/pmcp_port.sv
// Purpose: management port with soft reset and loopback registers
// Assumes: host holds request while stall is high
// Notes:   transceiver space is passed through to reconfig port
`timescale 1ns/1ps
`default_nettype none
`include "pmcp_cfg.svh"
module pmcp_port #(
  parameter int LANES = 4
) (
  input  wire logic                         mclk_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         mgmt_rst_i,
  input  wire logic [`PMCP_BASE_ADDR_W+$clog2(LANES)-1:0] mgmt_addr_i,
  input  wire logic                         mgmt_write_i,
  input  wire logic [31:0]                  mgmt_write_word_i,
  input  wire logic                         mgmt_read_i,
  output logic      [31:0]                  mgmt_read_word_o,
  output logic                              mgmt_stall_o,
  input  wire logic                         retune_busy_i,
  output logic                              xcvr_read_o,
  output logic                              xcvr_write_o,
  output logic      [`PMCP_BASE_ADDR_W+$clog2(LANES)-2:0] xcvr_addr_o,
  output logic      [31:0]                  xcvr_write_word_o,
  input  wire logic [31:0]                  xcvr_read_word_i,
  input  wire logic                         xcvr_stall_i,
  output logic                              core_reset_o,
  output logic      [LANES-1:0]             loopback_o,
  output logic      [LANES-1:0]             tx_serial_o,
  input  wire logic [LANES-1:0]             rx_serial_i,
  input  wire logic [LANES-1:0]             tx_lane_data_i,
  output logic      [LANES-1:0]             rx_lane_data_o
);
  import pmcp_pkg::*;

  // ****************************************
  // parameter check
  // ****************************************
  // address width grows with lanes
  localparam int AW   = `PMCP_BASE_ADDR_W + $clog2(LANES);
  localparam int OFSW = `PMCP_BASE_ADDR_W;
  generate
    // one lane leaves no spare msb above the offset
    if (LANES < 2 || LANES > 32) begin : g_bad_lanes
      $error("LANES must be 2 to 32");
    end
    if (AW <= OFSW) begin : g_bad_addr
      $error("address has no space select bit");
    end
    if (`PMCP_SEQ_CYCLES == 8'h00) begin : g_bad_seq
      $error("reset sequence length must be nonzero");
    end
  endgenerate

  // ****************************************
  // decode helpers
  // ****************************************
  // offset compare, shared by write and read paths
  function automatic logic pmcp_hit(input logic [9:0] addr_ofs,
                                    input logic [9:0] target);
    return addr_ofs == target;
  endfunction : pmcp_hit

  // ****************************************
  // address decode
  // ****************************************
  pmcp_state_t       state_r;
  logic              busy_req;
  logic              xcvr_sel;
  logic [9:0]        ofs;
  logic              soft_wr;
  logic              soft_rd;
  logic              xcvr_done;
  logic [31:0]       reset_ctl_r;
  logic [LANES-1:0]  loop_r;
  logic [7:0]        seq_cnt_r;
  logic              rst_any;
  logic [31:0]       read_word_r;

  // read and write strobes are treated alike
  assign busy_req  = mgmt_read_i | mgmt_write_i;
  assign xcvr_sel  = mgmt_addr_i[AW-1];
  assign ofs       = mgmt_addr_i[9:0];
  // soft accesses only count in idle
  assign soft_wr   = (state_r == PMCP_IDLE) & mgmt_write_i & ~xcvr_sel;
  assign soft_rd   = (state_r == PMCP_IDLE) & mgmt_read_i & ~xcvr_sel;
  assign xcvr_done = (state_r == PMCP_XCVR_WAIT) & ~xcvr_stall_i;
  // level reset, soft bit as well
  assign rst_any   = mgmt_rst_i | reset_ctl_r[0];

  // ****************************************
  // reset sequencer
  // ****************************************
  // sequencer on management clock
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seq_cnt_r <= `PMCP_SEQ_CYCLES;
    end else if (rst_any) begin
      seq_cnt_r <= `PMCP_SEQ_CYCLES;
    end else if (seq_cnt_r != 8'h00) begin
      seq_cnt_r <= seq_cnt_r - 8'h01;
    end
  end
  // core held while reset or counting
  assign core_reset_o = rst_any | (seq_cnt_r != 8'h00);

  // ****************************************
  // access sequencing
  // ****************************************
  // stall until answer ready
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= PMCP_IDLE;
    end else if (mgmt_rst_i) begin
      state_r <= PMCP_IDLE;
    end else begin
      unique case (state_r)
        PMCP_IDLE: begin
          if (busy_req) begin
            state_r <= xcvr_sel ? PMCP_XCVR_WAIT : PMCP_ANSWER;
          end
        end
        PMCP_XCVR_WAIT: begin
          if (!xcvr_stall_i) begin
            state_r <= PMCP_ANSWER;
          end
        end
        PMCP_ANSWER: begin
          state_r <= PMCP_IDLE;
        end
        // spare code of the two-bit state
        default: begin
          state_r <= PMCP_IDLE;
        end
      endcase
    end
  end
  // stall is combinational so a held strobe sees it at once
  assign mgmt_stall_o = busy_req & (state_r != PMCP_ANSWER);

  // ****************************************
  // transceiver forwarding
  // ****************************************
  // address is passed without its select bit
  // forward transceiver space
  assign xcvr_read_o       = (state_r == PMCP_XCVR_WAIT) & mgmt_read_i;
  assign xcvr_write_o      = (state_r == PMCP_XCVR_WAIT) & mgmt_write_i;
  assign xcvr_addr_o       = mgmt_addr_i[AW-2:0];
  assign xcvr_write_word_o = mgmt_write_word_i;

  // ****************************************
  // soft registers
  // ****************************************
  // reset control word, written in idle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reset_ctl_r <= `PMCP_RST_RESET_CTL;
    end else if (mgmt_rst_i) begin
      reset_ctl_r <= `PMCP_RST_RESET_CTL;
    end else if (soft_wr && pmcp_hit(ofs, `PMCP_OFS_RESET_CTL)) begin
      reset_ctl_r <= mgmt_write_word_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loop_r <= LANES'(`PMCP_RST_LOOPBACK);
    end else if (mgmt_rst_i) begin
      loop_r <= LANES'(`PMCP_RST_LOOPBACK);
    end else if (soft_wr && pmcp_hit(ofs, `PMCP_OFS_LOOPBACK)) begin
      loop_r <= mgmt_write_word_i[LANES-1:0];
    end
  end
  assign loopback_o = loop_r;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      read_word_r <= `PMCP_DEAD_WORD;
    end else if (mgmt_rst_i) begin
      // global reset clears the answer too
      read_word_r <= `PMCP_DEAD_WORD;
    end else if (soft_rd) begin
      if (pmcp_hit(ofs, `PMCP_OFS_RESET_CTL)) begin
        read_word_r <= reset_ctl_r;
      end else if (pmcp_hit(ofs, `PMCP_OFS_LOOPBACK)) begin
        read_word_r <= 32'(loop_r);
      end else if (pmcp_hit(ofs, `PMCP_OFS_STATUS)) begin
        read_word_r <= {31'h0000_0000, core_reset_o};
      end else begin
        // unmapped offsets answer zero
        read_word_r <= `PMCP_DEAD_WORD;
      end
    end else if (xcvr_done && mgmt_read_i) begin
      // writes leave the last answer standing
      read_word_r <= xcvr_read_word_i;
    end
  end
  assign mgmt_read_word_o = read_word_r;

  // ****************************************
  // serial lanes
  // ****************************************
  // one pin pair per lane
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      // lanes stay quiet while the core is held
      assign tx_serial_o[gi]    = core_reset_o ? 1'b0 : tx_lane_data_i[gi];
      assign rx_lane_data_o[gi] = core_reset_o ? 1'b0 :
                                  (loop_r[gi] ? tx_lane_data_i[gi] : rx_serial_i[gi]);
    end
  endgenerate

  // retune busy has no function here
  logic unused_ok;
  assign unused_ok = retune_busy_i;
endmodule : pmcp_port
`default_nettype wire

// file: inc/pmcp_cfg.svh
// Purpose: constants for the phy management port
// Assumes: one management clock, 20 MHz
// Notes:   offsets are local to the soft register space
//
// Operation
// - management clock times port and sequencer
// - high level reset clears whole core
// - address width ten plus log2 lanes
// - top address bit selects target space
// - read strobe returns 32-bit read word
// - stall held until request can complete
// - one serial pin pair per lane
`ifndef PMCP_CFG_SVH
`define PMCP_CFG_SVH
`define PMCP_BASE_ADDR_W   10
`define PMCP_OFS_RESET_CTL 10'h000
`define PMCP_OFS_LOOPBACK  10'h001
`define PMCP_OFS_STATUS    10'h002
`define PMCP_RST_RESET_CTL 32'h0000_0000
`define PMCP_RST_LOOPBACK  32'h0000_0000
`define PMCP_SEQ_CYCLES    8'h10
`define PMCP_DEAD_WORD     32'h0000_0000
`endif

// file: inc/pmcp_pkg.sv
// Purpose: types for the phy management port
// Assumes: nothing
// Notes:   none
package pmcp_pkg;
  typedef enum logic [1:0] {
    PMCP_IDLE,
    PMCP_XCVR_WAIT,
    PMCP_ANSWER
  } pmcp_state_t;
endpackage : pmcp_pkg

// file: verif/pmcp_port_asserts.sv
// Purpose: port checks for pmcp_port
// Assumes: one clock, async low reset
// Notes:   soft space has msb 0
`timescale 1ns/1ps
`default_nettype none
module pmcp_port_asserts #(
  parameter int LANES = 4
) (
  input wire logic mclk_i, rst_b_i, mgmt_rst_i, mgmt_write_i, mgmt_read_i,
  input wire logic [10+$clog2(LANES)-1:0] mgmt_addr_i,
  input wire logic [31:0] mgmt_read_word_o,
  input wire logic mgmt_stall_o, xcvr_read_o, xcvr_write_o, xcvr_stall_i, core_reset_o,
  input wire logic [10+$clog2(LANES)-2:0] xcvr_addr_o
);
  localparam int M = 10+$clog2(LANES)-1;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_soft_rd;
    $rose(mgmt_read_i) && !mgmt_addr_i[M] && !mgmt_rst_i;
  endsequence
  a_soft_no_fwd: assert property (!mgmt_addr_i[M] |-> !xcvr_read_o && !xcvr_write_o)
    else $error("soft access forwarded");
  a_fwd_xcvr: assert property (xcvr_read_o |-> mgmt_addr_i[M] && mgmt_read_i
    && xcvr_addr_o == mgmt_addr_i[M-1:0]) else $error("bad forward");
  a_stall_fwd: assert property ((xcvr_read_o || xcvr_write_o) && xcvr_stall_i |-> mgmt_stall_o)
    else $error("stall not passed");
  a_stall_take: assert property (s_soft_rd |-> mgmt_stall_o) else $error("no stall");
  a_soft_answer: assert property (s_soft_rd |=> !mgmt_stall_o) else $error("late answer");
  a_read_stands: assert property (!mgmt_read_i && !mgmt_rst_i ##1 !mgmt_read_i
    |-> $stable(mgmt_read_word_o)) else $error("read word moved");
  a_rst_core: assert property (mgmt_rst_i |-> core_reset_o) else $error("core not reset");
  a_rst_hold: assert property ($fell(mgmt_rst_i) |-> core_reset_o[*8])
    else $error("core reset short");
endmodule : pmcp_port_asserts
bind pmcp_port pmcp_port_asserts #(.LANES(LANES)) i_pmcp_port_asserts (.*);
`default_nettype wire

// file: verif/pmcp_xcvr_model.sv
// Purpose: reconfig side responder
// Assumes: strobe held while stalled
// Notes:   lat_i sets stall cycles
`timescale 1ns/1ps
`default_nettype none
module pmcp_xcvr_model (
  input  wire logic        clk_i, rd_i, wr_i,
  input  wire logic [1:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  lat_i,
  output logic      [31:0] rdata_o,
  output logic             stall_o
);
  logic [31:0] mem [4];
  logic [3:0]  cnt_r;
  always_ff @(posedge clk_i) begin
    cnt_r <= (rd_i || wr_i) ? cnt_r + {3'h0, stall_o} : 4'h0;
    if (wr_i && !stall_o) mem[addr_i] <= wdata_i;
  end
  assign stall_o = (rd_i || wr_i) && cnt_r < lat_i;
  // inverted data when not reading, so a late capture shows up
  assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
endmodule : pmcp_xcvr_model
`default_nettype wire

// file: verif/pmcp_port_test.sv
// Purpose: bench for pmcp_port
// Assumes: 50 ns clock, four lanes
// Notes:   serial pins looped back inverted
`timescale 1ns/1ps
`default_nettype none
module pmcp_port_test;
  localparam int LANES = 4;
  logic mclk_i = 0, rst_b_i = 0, mgmt_rst_i = 0, mgmt_write_i = 0, mgmt_read_i = 0;
  logic [11:0] mgmt_addr_i = 12'h000;
  logic [31:0] mgmt_write_word_i = 0, mgmt_read_word_o, xcvr_write_word_o, xcvr_read_word_i, q;
  logic mgmt_stall_o, xcvr_read_o, xcvr_write_o, xcvr_stall_i, core_reset_o;
  logic retune_busy_i = 0;
  logic [10:0] xcvr_addr_o;
  logic [3:0] loopback_o, tx_serial_o, rx_lane_data_o, tx_lane_data_i = 0, lat = 0;
  wire logic [3:0] rx_serial_i = ~tx_serial_o;
  int err_total = 0, cmp_count = 0;
  pmcp_port #(.LANES(LANES)) i_pmcp_port (.*);
  pmcp_xcvr_model i_pmcp_xcvr_model (.clk_i(mclk_i), .rd_i(xcvr_read_o), .wr_i(xcvr_write_o),
    .addr_i(xcvr_addr_o[1:0]), .wdata_i(xcvr_write_word_o), .lat_i(lat),
    .rdata_o(xcvr_read_word_i), .stall_o(xcvr_stall_i));
  initial forever #25 mclk_i = ~mclk_i;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    mgmt_addr_i <= a;
    mgmt_write_word_i <= d;
    mgmt_write_i <= w;
    mgmt_read_i <= !w;
    do begin
      @(posedge mclk_i);
      n++;
    end while (mgmt_stall_o !== 1'b0 && n < 64);
    if (mgmt_stall_o !== 1'b0) begin
      err_total++;
      $display("CHECK FAILED %0t stall never dropped", $time);
    end
    q = mgmt_read_word_o;
    mgmt_write_i <= 0;
    mgmt_read_i <= 0;
    @(posedge mclk_i);
  endtask : acc
  task automatic t_soft;
    acc(1, 12'h001, 32'h0000_000F);
    acc(0, 12'h001, 0);
    chk(q, 32'h0000_000F);
    tx_lane_data_i <= 4'hA;
    @(posedge mclk_i);
    chk({loopback_o, rx_lane_data_o}, 8'hFA);
    chk(tx_serial_o, 4'hA);
    acc(1, 12'h001, 0);
    chk(rx_lane_data_o, 4'h5);
    acc(1, 12'h003, 32'h0000_FFFF);
    acc(0, 12'h003, 0);
    chk(q, 32'h0000_0000);
    acc(1, 12'h000, 32'h0000_0001);
    chk({core_reset_o, tx_serial_o, rx_lane_data_o}, 9'h100);
    acc(0, 12'h000, 0);
    chk(q, 32'h0000_0001);
    acc(1, 12'h000, 0);
    repeat (17) @(posedge mclk_i);
    chk({core_reset_o, rx_lane_data_o}, 5'h05);
    $display("soft done");
  endtask : t_soft
  task automatic t_xcvr;
    lat <= 4'h3;
    acc(1, 12'h801, 32'h1234_5678);
    acc(0, 12'h801, 0);
    chk(q, 32'h1234_5678);
    lat <= 4'h0;
    acc(0, 12'h801, 0);
    chk(q, 32'h1234_5678);
    acc(1, 12'h802, 32'hCAFE_0002);
    acc(0, 12'h802, 0);
    chk(q, 32'hCAFE_0002);
    $display("xcvr done");
  endtask : t_xcvr
  task automatic t_reset;
    mgmt_rst_i <= 1;
    repeat (2) @(posedge mclk_i);
    chk({core_reset_o, loopback_o}, 5'h10);
    chk(mgmt_read_word_o, 32'h0000_0000);
    mgmt_rst_i <= 0;
    repeat (20) @(posedge mclk_i);
    acc(0, 12'h002, 0);
    chk({core_reset_o, q[0]}, 2'b00);
    $display("reset done");
  endtask : t_reset
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1;
    repeat (20) @(posedge mclk_i);
    t_soft();
    t_xcvr();
    t_reset();
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge mclk_i);
    err_total++;
    print_verdict();
  end
endmodule : pmcp_port_test
`default_nettype wire
